// ---- core/sffoc_pkg.sv ----
package sffoc_pkg;

  // ==========================================================
  // geometry
  localparam int DEPTH_DEF = 64;
  localparam int DEPTH_MIN = 64;
  localparam int DEPTH_MAX = 8192;
  localparam int DATA_W    = 9;
  localparam int OFS_W     = 8;
  localparam int OFS_NUM   = 4;

  // ==========================================================
  // offset register and read data register defaults
  localparam logic [7:0] EMPTY_LOW_RST  = 8'h07;
  localparam logic [7:0] EMPTY_HIGH_RST = 8'h00;
  localparam logic [7:0] FULL_LOW_RST   = 8'h07;
  localparam logic [7:0] FULL_HIGH_RST  = 8'h00;
  localparam logic [8:0] READ_DATA_RST  = 9'h000;

  // ==========================================================
  // types
  typedef enum logic {
    MODE_DUAL_ENABLE,
    MODE_PROG_FLAGS
  } sffoc_mode_e;

  typedef enum logic [1:0] {
    SEL_EMPTY_LOW,
    SEL_EMPTY_HIGH,
    SEL_FULL_LOW,
    SEL_FULL_HIGH
  } sffoc_sel_e;

  typedef struct packed {
    logic full_n;
    logic almost_full_n;
    logic almost_empty_n;
    logic empty_n;
  } sffoc_flags_s;

  localparam sffoc_flags_s FLAGS_RST = '{full_n: 1'b1, almost_full_n: 1'b1,
                                         almost_empty_n: 1'b0, empty_n: 1'b0};

endpackage

// ---- core/sffoc_ram.sv ----
`timescale 1ns/10ps

module sffoc_ram #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 64
) (
  // clock
  input  wire logic                     clk_in,
  // write port
  input  wire logic                     wr_en_in,
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr_in,
  input  wire logic [WIDTH-1:0]         wr_data_in,
  // read port
  input  wire logic                     rd_en_in,
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr_in,
  output logic      [WIDTH-1:0]         rd_data_out
);

  // ==========================================================
  // storage, no reset so it maps onto block ram
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] rd_data_r;

  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem_r[wr_addr_in] <= wr_data_in;
    end
    if (rd_en_in) begin
      rd_data_r <= mem_r[rd_addr_in];
    end
  end

  assign rd_data_out = rd_data_r;

endmodule

// ---- core/sffoc_fifo_ctrl.sv ----
`timescale 1ns/10ps

// Function
// - pin high during reset makes it a second active-high write enable
// - pin low during reset selects programmable flags, pin becomes load
// - dual mode: enable low and second enable high writes next location
// - dual mode: either enable inactive holds input, no word written
// - full fifo drives full flag low and ignores both write enables
// - a read on a full fifo raises full flag on a write edge
// - four 8-bit offset registers, loadable from inputs, readable on outputs
// - load low writes empty low, empty high, full low, full high, wraps
// - partial load keeps sequence position for the next load
// - load high writes fifo; first enable high is no operation
// - load low and both read enables low read offsets in same order
// - full flag low after exactly depth writes with no reads
// - full and almost-full flags change only on write edges
// - empty flag low when read pointer equals write pointer and count is below depth
// - empty and almost-empty flags change only on read edges
// - almost-full low once count reaches depth minus full offset
// - default full offset gives almost-full at seven below full
// - almost-empty low when count is within empty offset of empty
// - default empty offset gives almost-empty at seven above empty
// - reset clears pointers, output register, restores offset defaults
// - reset drives full flags high and empty flags low
module sffoc_fifo_ctrl #(
  parameter int DEPTH = sffoc_pkg::DEPTH_DEF
) (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // write side
  input  wire logic [8:0] write_data_in,
  input  wire logic       primary_write_enable_n_in,
  input  wire logic       second_enable_or_load_in,
  // read side
  input  wire logic       read_enable_a_n_in,
  input  wire logic       read_enable_b_n_in,
  output logic      [8:0] read_data_out,
  // status flags
  output logic            full_flag_n_out,
  output logic            almost_full_flag_n_out,
  output logic            almost_empty_flag_n_out,
  output logic            empty_flag_n_out
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

  // ==========================================================
  // parameter check
  if (DEPTH < sffoc_pkg::DEPTH_MIN || DEPTH > sffoc_pkg::DEPTH_MAX ||
      (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("depth must be a power of two from 64 to 8192");
  end

  // ==========================================================
  // helpers
  function automatic sffoc_pkg::sffoc_sel_e next_sel(input sffoc_pkg::sffoc_sel_e s);
    case (s)
      sffoc_pkg::SEL_EMPTY_LOW:  next_sel = sffoc_pkg::SEL_EMPTY_HIGH;
      sffoc_pkg::SEL_EMPTY_HIGH: next_sel = sffoc_pkg::SEL_FULL_LOW;
      sffoc_pkg::SEL_FULL_LOW:   next_sel = sffoc_pkg::SEL_FULL_HIGH;
      default:                   next_sel = sffoc_pkg::SEL_EMPTY_LOW;
    endcase
  endfunction

  // 16-bit offset against a count; offset may exceed depth so widen first
  function automatic logic reaches_full(input logic [CW-1:0] cnt, input logic [15:0] m);
    reaches_full = ({1'b0, 16'(cnt)} + {1'b0, m}) >= {1'b0, 16'(DEPTH_C)};
  endfunction

  // ==========================================================
  // state
  sffoc_pkg::sffoc_mode_e   mode_r,       mode_nxt;
  logic                     strap_done_r, strap_done_nxt;
  sffoc_pkg::sffoc_sel_e    wr_sel_r,     wr_sel_nxt;
  sffoc_pkg::sffoc_sel_e    rd_sel_r,     rd_sel_nxt;
  logic [3:0][7:0]          ofs_r,        ofs_nxt;
  logic [AW-1:0]            wptr_r,       wptr_nxt;
  logic [AW-1:0]            rptr_r,       rptr_nxt;
  logic [CW-1:0]            count_r,      count_nxt;
  sffoc_pkg::sffoc_flags_s  flags_r,      flags_nxt;
  logic [8:0]               rdata_r,      rdata_nxt;
  logic                     pend_r,       pend_nxt;

  logic                     load_low;
  logic                     both_ren;
  logic                     fifo_wr;
  logic                     fifo_rd;
  logic                     ofs_wr;
  logic                     ofs_rd;
  logic [15:0]              empty_ofs;
  logic [15:0]              full_ofs;
  logic [7:0]               ofs_rd_byte;
  logic [8:0]               mem_rdata;

  // ==========================================================
  // request decode
  always_comb begin
    load_low = (mode_r == sffoc_pkg::MODE_PROG_FLAGS) && !second_enable_or_load_in;
    both_ren = !read_enable_a_n_in && !read_enable_b_n_in;
    // second enable high in dual mode, load high in flag mode: same pin level
    fifo_wr  = strap_done_r && !primary_write_enable_n_in && second_enable_or_load_in &&
               flags_r.full_n;
    ofs_wr   = strap_done_r && load_low && !primary_write_enable_n_in;
    // a simultaneous offset read and write is the controller's hazard to avoid
    ofs_rd   = strap_done_r && load_low && both_ren;
    fifo_rd  = strap_done_r && !load_low && both_ren && flags_r.empty_n;
    empty_ofs   = {ofs_r[sffoc_pkg::SEL_EMPTY_HIGH], ofs_r[sffoc_pkg::SEL_EMPTY_LOW]};
    full_ofs    = {ofs_r[sffoc_pkg::SEL_FULL_HIGH], ofs_r[sffoc_pkg::SEL_FULL_LOW]};
    ofs_rd_byte = ofs_r[rd_sel_r];
  end

  // ==========================================================
  // mode strap
  // caught on the first edge after release, so hold the pin until then
  always_comb begin
    strap_done_nxt = 1'b1;
    mode_nxt       = mode_r;
    if (!strap_done_r) begin
      mode_nxt = second_enable_or_load_in ? sffoc_pkg::MODE_DUAL_ENABLE
                                          : sffoc_pkg::MODE_PROG_FLAGS;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      strap_done_r <= 1'b0;
      mode_r       <= sffoc_pkg::MODE_DUAL_ENABLE;
    end else begin
      strap_done_r <= strap_done_nxt;
      mode_r       <= mode_nxt;
    end
  end

  // ==========================================================
  // offset registers and sequence positions
  always_comb begin
    ofs_nxt    = ofs_r;
    wr_sel_nxt = wr_sel_r;
    rd_sel_nxt = rd_sel_r;
    if (ofs_wr) begin
      ofs_nxt[wr_sel_r] = write_data_in[7:0];
      wr_sel_nxt        = next_sel(wr_sel_r);
    end
    if (ofs_rd) begin
      rd_sel_nxt = next_sel(rd_sel_r);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ofs_r[sffoc_pkg::SEL_EMPTY_LOW]  <= sffoc_pkg::EMPTY_LOW_RST;
      ofs_r[sffoc_pkg::SEL_EMPTY_HIGH] <= sffoc_pkg::EMPTY_HIGH_RST;
      ofs_r[sffoc_pkg::SEL_FULL_LOW]   <= sffoc_pkg::FULL_LOW_RST;
      ofs_r[sffoc_pkg::SEL_FULL_HIGH]  <= sffoc_pkg::FULL_HIGH_RST;
      wr_sel_r <= sffoc_pkg::SEL_EMPTY_LOW;
      rd_sel_r <= sffoc_pkg::SEL_EMPTY_LOW;
    end else begin
      ofs_r    <= ofs_nxt;
      wr_sel_r <= wr_sel_nxt;
      rd_sel_r <= rd_sel_nxt;
    end
  end

  // ==========================================================
  // pointers, count and flags
  // one clock serves as both write and read edge, so every flag
  // moves on an edge of its own domain by construction
  always_comb begin
    wptr_nxt  = fifo_wr ? AW'(wptr_r + 1'b1) : wptr_r;
    rptr_nxt  = fifo_rd ? AW'(rptr_r + 1'b1) : rptr_r;
    count_nxt = count_r;
    if (fifo_wr && !fifo_rd) begin
      count_nxt = CW'(count_r + 1'b1);
    end else if (fifo_rd && !fifo_wr) begin
      count_nxt = CW'(count_r - 1'b1);
    end
    flags_nxt.full_n         = (count_nxt != DEPTH_C);
    flags_nxt.almost_full_n  = !reaches_full(count_nxt, full_ofs);
    flags_nxt.empty_n        = (count_nxt != '0);
    flags_nxt.almost_empty_n = (16'(count_nxt) > empty_ofs);
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wptr_r  <= '0;
      rptr_r  <= '0;
      count_r <= '0;
      flags_r <= sffoc_pkg::FLAGS_RST;
    end else begin
      wptr_r  <= wptr_nxt;
      rptr_r  <= rptr_nxt;
      count_r <= count_nxt;
      flags_r <= flags_nxt;
    end
  end

  // ==========================================================
  // storage
  sffoc_ram #(
    .WIDTH (sffoc_pkg::DATA_W),
    .DEPTH (DEPTH)
  ) u_ram (
    .clk_in      (clk_in),
    .wr_en_in    (fifo_wr),
    .wr_addr_in  (wptr_r),
    .wr_data_in  (write_data_in),
    .rd_en_in    (fifo_rd),
    .rd_addr_in  (rptr_r),
    .rd_data_out (mem_rdata)
  );

  // ==========================================================
  // output register
  // fifo words land one edge after the ram register; costs a cycle
  // of latency but keeps the pin straight off a flop
  always_comb begin
    pend_nxt  = fifo_rd;
    rdata_nxt = rdata_r;
    if (pend_r) begin
      rdata_nxt = mem_rdata;
    end
    if (ofs_rd) begin
      rdata_nxt = {1'b0, ofs_rd_byte};
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pend_r  <= 1'b0;
      rdata_r <= sffoc_pkg::READ_DATA_RST;
    end else begin
      pend_r  <= pend_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign read_data_out           = rdata_r;
  assign full_flag_n_out         = flags_r.full_n;
  assign almost_full_flag_n_out  = flags_r.almost_full_n;
  assign almost_empty_flag_n_out = flags_r.almost_empty_n;
  assign empty_flag_n_out        = flags_r.empty_n;

  // ==========================================================
  // checks
  sequence s_load_edge;
    ofs_wr;
  endsequence

  // position before the load is taken by $past; a plain argument would be
  // re-read after the step and compare the new position with itself
  sequence s_next_pos;
    ##1 wr_sel_r == next_sel($past(wr_sel_r));
  endsequence

  a_strap_mode_pick: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    !strap_done_r |=> mode_r == ($past(second_enable_or_load_in) ?
      sffoc_pkg::MODE_DUAL_ENABLE : sffoc_pkg::MODE_PROG_FLAGS))
    else $error("mode not taken from strap");

  a_dual_write_step: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    strap_done_r && mode_r == sffoc_pkg::MODE_DUAL_ENABLE && !primary_write_enable_n_in &&
    second_enable_or_load_in && full_flag_n_out |=> wptr_r == AW'($past(wptr_r) + 1'b1))
    else $error("enabled write did not advance");

  a_write_hold_idle: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (primary_write_enable_n_in || !second_enable_or_load_in) |=> $stable(wptr_r))
    else $error("write taken while disabled");

  a_full_blocks_write: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    !full_flag_n_out && !both_ren |=> $stable(wptr_r) && !full_flag_n_out)
    else $error("write on full fifo");

  a_full_at_depth: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    full_flag_n_out == (count_r != DEPTH_C))
    else $error("full flag disagrees with count");

  a_empty_on_equal: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (wptr_r == rptr_r && count_r != DEPTH_C) |-> !empty_flag_n_out && !almost_empty_flag_n_out)
    else $error("empty flag high with equal pointers");

  a_load_sequence: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    s_load_edge |-> s_next_pos)
    else $error("offset load order broken");

  a_offset_readback: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    ofs_rd |=> read_data_out == {1'b0, $past(ofs_rd_byte)} && rd_sel_r == next_sel($past(rd_sel_r)))
    else $error("offset readback wrong");

  a_almost_full_level: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    !ofs_wr |=> almost_full_flag_n_out == !reaches_full(count_r, full_ofs))
    else $error("almost-full threshold wrong");

  a_almost_empty_level: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    !ofs_wr |=> almost_empty_flag_n_out == (16'(count_r) > empty_ofs))
    else $error("almost-empty threshold wrong");

endmodule

// ---- test/sffoc_partner.sv ----
`timescale 1ns/10ps

// ==========================================================
// writer and reader logic facing the fifo
module sffoc_partner (
  // clock
  input  wire logic       clk_in,
  // write side
  output logic      [8:0] write_data_out,
  output logic            wen_n_out,
  output logic            pin_out,
  // read side
  output logic            ren_a_n_out,
  output logic            ren_b_n_out
);
  // idle levels, applied while reset is held; the strap is left to set_pin
  task automatic idle();
    write_data_out = 9'h000;
    wen_n_out      = 1'b1;
    ren_a_n_out    = 1'b1;
    ren_b_n_out    = 1'b1;
  endtask

  // caller changes the strap only just after a falling edge
  task automatic set_pin(input logic v);
    pin_out = v;
  endtask

  // one word per call; data is scrambled once the enable drops
  task automatic wr(input logic [8:0] d);
    @(negedge clk_in);
    write_data_out = d;
    wen_n_out = 1'b0;
    @(negedge clk_in);
    wen_n_out = 1'b1;
    write_data_out = ~d;
  endtask

  // each task owns the pins alone, so offset read and write never overlap
  // one enable left high must hold the output register and the pointers
  task automatic rd(input logic a_n = 1'b0, input logic b_n = 1'b0);
    @(negedge clk_in);
    ren_a_n_out = a_n;
    ren_b_n_out = b_n;
    @(negedge clk_in);
    ren_a_n_out = 1'b1;
    ren_b_n_out = 1'b1;
  endtask
endmodule

// ---- test/sffoc_testbench.sv ----
`timescale 1ns/10ps

// ==========================================================
// self-checking bench for the fifo control block
module testbench;
  localparam int DEPTH = 64;

  logic                    clk_in;
  logic                    rst_n;
  logic [8:0]              wdata;
  logic                    wen_n;
  logic                    pin;
  logic                    ren_a_n;
  logic                    ren_b_n;
  logic [8:0]              rdata;
  wire sffoc_pkg::sffoc_flags_s fl;
  int                      err_total = 0;
  int                      checks = 0;

  // starts unknown, first inversion lands high
  always #2 clk_in = (clk_in !== 1'b1);

  sffoc_partner u_p (
    .clk_in        (clk_in),
    .write_data_out(wdata),
    .wen_n_out     (wen_n),
    .pin_out       (pin),
    .ren_a_n_out   (ren_a_n),
    .ren_b_n_out   (ren_b_n)
  );

  sffoc_fifo_ctrl #(.DEPTH(DEPTH)) dut (
    .clk_in                   (clk_in),
    .rst_n_in                 (rst_n),
    .write_data_in            (wdata),
    .primary_write_enable_n_in(wen_n),
    .second_enable_or_load_in (pin),
    .read_enable_a_n_in       (ren_a_n),
    .read_enable_b_n_in       (ren_b_n),
    .read_data_out            (rdata),
    .full_flag_n_out          (fl.full_n),
    .almost_full_flag_n_out   (fl.almost_full_n),
    .almost_empty_flag_n_out  (fl.almost_empty_n),
    .empty_flag_n_out         (fl.empty_n)
  );

  // ==========================================================
  // helpers
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic sffoc_pkg::sffoc_flags_s exp_fl(input int c, input int n, input int m);
    sffoc_pkg::sffoc_flags_s f;
    f.full_n = (c != DEPTH);
    f.almost_full_n = (c < DEPTH - m);
    f.almost_empty_n = (c > n);
    f.empty_n = (c != 0);
    return f;
  endfunction

  task automatic chk_fl(input int c, input int n, input int m);
    chk({5'h00, fl}, {5'h00, exp_fl(c, n, m)});
  endtask

  // strap must stay put through the first edge after release
  task automatic do_reset(input logic mode);
    @(negedge clk_in);
    rst_n = 1'b0;
    u_p.idle();
    u_p.set_pin(mode);
    repeat (12) @(negedge clk_in);
    rst_n = 1'b1;
    @(negedge clk_in);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_dual();
    do_reset(1'b1);
    chk(rdata, 9'h000);
    chk_fl(0, 7, 7);
    u_p.set_pin(1'b0);
    u_p.wr(9'h1FF);
    u_p.set_pin(1'b1);
    chk_fl(0, 7, 7);
    for (int c = 1; c <= DEPTH; c++) begin
      u_p.wr(9'(c - 1) ^ 9'h155);
      chk_fl(c, 7, 7);
    end
    u_p.wr(9'h0AA);
    chk_fl(DEPTH, 7, 7);
    u_p.rd(1'b0, 1'b1);
    chk_fl(DEPTH, 7, 7);
    u_p.rd(1'b1, 1'b0);
    chk_fl(DEPTH, 7, 7);
    @(negedge clk_in);
    chk(rdata, 9'h000);
    for (int r = 0; r < DEPTH; r++) begin
      u_p.rd();
      chk_fl(DEPTH - 1 - r, 7, 7);
      @(negedge clk_in);
      chk(rdata, 9'(r) ^ 9'h155);
    end
    u_p.rd();
    @(negedge clk_in);
    chk(rdata, 9'(DEPTH - 1) ^ 9'h155);
    $display("test dual_enable done");
  endtask

  task automatic t_prog();
    logic [8:0] exp_q [5];
    exp_q = '{9'h002, 9'h000, 9'h004, 9'h000, 9'h002};
    do_reset(1'b0);
    for (int i = 0; i < 4; i++) begin
      u_p.rd();
      chk(rdata, (i % 2 == 0) ? 9'h007 : 9'h000);
    end
    u_p.wr(9'h103);
    u_p.wr(9'h000);
    u_p.set_pin(1'b1);
    u_p.wr(9'h0C3);
    chk_fl(1, 3, 7);
    u_p.set_pin(1'b0);
    u_p.wr(9'h004);
    u_p.wr(9'h000);
    u_p.wr(9'h002);
    for (int i = 0; i < 5; i++) begin
      u_p.rd();
      chk(rdata, exp_q[i]);
    end
    u_p.set_pin(1'b1);
    for (int c = 2; c <= DEPTH; c++) begin
      u_p.wr(9'(c));
      chk_fl(c, 2, 4);
    end
    u_p.rd();
    @(negedge clk_in);
    chk(rdata, 9'h0C3);
    $display("test prog_flags done");
  endtask

  // ==========================================================
  // run control
  task automatic wrap_up();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    t_dual();
    t_prog();
    wrap_up();
  end

  // both scenarios need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_in);
    err_total++;
    wrap_up();
  end
endmodule
